// ===== verilog/ddsc_pkg.sv
// Shared constants and helpers for the dual converter serial control link
package ddsc_pkg;

    // ------------------------------------------------------------------
    // Serial word layout
    // ------------------------------------------------------------------
    localparam int WORD_BITS = 24;
    localparam int DATA_BITS = 16;
    localparam int RW_BIT = 23;
    localparam int REG_HI = 21;
    localparam int REG_LO = 19;
    localparam int CH_BIT = 16;
    localparam int HDR_LO = 16;
    localparam logic [2:0] REG_DAC = 3'h0;
    localparam logic [2:0] REG_CTRL = 3'h1;
    localparam logic [2:0] REG_GPIO = 3'h2;
    localparam int CTRL_DAISY_BIT = 0;
    localparam int GPIO_DIR_LO = 0;
    localparam int GPIO_OUT_LO = 2;
    localparam int GPIO_IN_LO = 4;

    // ------------------------------------------------------------------
    // Converter codes
    // ------------------------------------------------------------------
    localparam logic [15:0] DAC_CLEAR_CODE = 16'h0000;
    localparam logic [15:0] ZERO_VOLT_CODE = 16'h8000;
    localparam logic [15:0] SIGN_FLIP = 16'h8000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CORE_CLK_MHZ = 100;
    localparam int CORE_CLK_NS = 10;
    localparam int SCLK_MAX_MHZ = 30;
    localparam int FRAME_HIGH_MIN_NS = 90;
    // Least half period of the serial clock, rounded up
    localparam int SCLK_MIN_HALF_CYC =
        (CORE_CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
    localparam int FRAME_GAP_CYC =
        (FRAME_HIGH_MIN_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

    // ------------------------------------------------------------------
    // Controller register map (APB byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_TX = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_RX = 8'h0C;
    localparam int CTRL_LOAD_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int CTRL_CLAMP_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h7;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_MON_BIT = 1;

    // Register code to offset binary, the form the converter core uses
    function automatic logic [15:0] to_offset_binary(
        input logic [15:0] code,
        input logic offset_fmt
    );
        return offset_fmt ? code : (code ^ SIGN_FLIP);
    endfunction

endpackage

// ===== verilog/ddsc_link_if.sv
// Serial link between controller and converter
`timescale 1ns/1ps
interface ddsc_link_if;
    logic sclk;
    logic frame_n;
    logic serial_bit_in;
    logic serial_bit_out;
    logic output_load_n;
    logic clear_edge_n;
    logic output_clamp_in_n;
    logic monitor_reset_out;

    modport host
    (
        output sclk,
        output frame_n,
        output serial_bit_in,
        input serial_bit_out,
        output output_load_n,
        output clear_edge_n,
        output output_clamp_in_n,
        input monitor_reset_out
    );

    modport dev
    (
        input sclk,
        input frame_n,
        input serial_bit_in,
        output serial_bit_out,
        input output_load_n,
        input clear_edge_n,
        input output_clamp_in_n,
        output monitor_reset_out
    );
endinterface

// ===== verilog/ddsc_dev.sv
// Converter end: serial shift logic, register update and pin control
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps

module ddsc_dev
(
    input wire logic core_clk,
    input wire logic reset_n,
    ddsc_link_if.dev link,
    input wire logic code_format_select,
    input wire logic supply_good,
    input wire logic gp_pin_zero_i,
    output logic gp_pin_zero_o,
    output logic gp_pin_zero_oe,
    input wire logic gp_pin_one_i,
    output logic gp_pin_one_o,
    output logic gp_pin_one_oe,
    output logic [15:0] dac_code_a,
    output logic [15:0] dac_code_b
);

    // ------------------------------------------------------------------
    // State of the serial and core clock domains
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ddsc_pkg::WORD_BITS-1:0] shift;
    } ddsc_lk_type;

    typedef struct packed {
        logic frm_s1;
        logic frm_s2;
        logic frm_d;
        logic ld_s1;
        logic ld_s2;
        logic ld_d;
        logic clr_s1;
        logic clr_s2;
        logic clr_d;
        logic clp_s1;
        logic clp_s2;
        logic mon_s1;
        logic mon_s2;
        logic fmt_s1;
        logic fmt_s2;
        logic [1:0] gpi_s1;
        logic [1:0] gpi_s2;
        logic [1:0][15:0] in_reg;
        logic [1:0][15:0] dac_reg;
        logic [1:0] pend;
        logic daisy;
        logic [1:0] gp_dir;
        logic [1:0] gp_out;
        logic [ddsc_pkg::WORD_BITS-1:0] rb_word;
        logic rb_pend;
        logic mon_out;
        logic [1:0][15:0] code;
    } ddsc_dev_type;

    ddsc_lk_type lk_ff;
    ddsc_lk_type nxt_lk;
    ddsc_dev_type dv_ff;
    ddsc_dev_type nxt_dv;
    logic first_bit_ff;
    logic [ddsc_pkg::WORD_BITS-1:0] word;
    logic rd;
    logic [2:0] regsel;
    logic ch;
    logic [15:0] data;
    logic [15:0] rb_val;

    // ------------------------------------------------------------------
    // Serial clock domain
    // ------------------------------------------------------------------

    // First-bit flag is set by the frame signal itself, since the serial
    // clock may stop as soon as the frame ends
    always_ff @(negedge link.sclk or posedge link.frame_n)
    begin
        if (link.frame_n)
            first_bit_ff <= 1'b1;
        else
            first_bit_ff <= 1'b0;
    end

    // Shift one bit per falling edge while framed; a pending readback
    // word is loaded in on the first edge of the next frame
    always_comb
    begin
        nxt_lk = lk_ff;
        if (!link.frame_n)
        begin
            if (first_bit_ff && dv_ff.rb_pend)
                nxt_lk.shift = {dv_ff.rb_word[ddsc_pkg::WORD_BITS-2:0],
                                link.serial_bit_in};
            else
                nxt_lk.shift = {lk_ff.shift[ddsc_pkg::WORD_BITS-2:0],
                                link.serial_bit_in};
        end
    end

    // Data path only; holds no control state, so no reset needed
    always_ff @(negedge link.sclk)
    begin
        lk_ff <= nxt_lk;
    end

    // Output bit is the register head with daisy set or a readback pending, else low; readback shows its first bit
    // before any edge of the frame has arrived
    always_comb
    begin
        if (!(dv_ff.daisy || dv_ff.rb_pend))
            link.serial_bit_out = 1'b0;
        else if (first_bit_ff && dv_ff.rb_pend)
            link.serial_bit_out =
                dv_ff.rb_word[ddsc_pkg::WORD_BITS-1];
        else
            link.serial_bit_out =
                lk_ff.shift[ddsc_pkg::WORD_BITS-1];
    end

    // ------------------------------------------------------------------
    // Word decode; shift contents are stable while the frame is high
    // ------------------------------------------------------------------
    always_comb
    begin
        word = lk_ff.shift;
        rd = word[ddsc_pkg::RW_BIT];
        regsel = word[ddsc_pkg::REG_HI:ddsc_pkg::REG_LO];
        ch = word[ddsc_pkg::CH_BIT];
        data = word[ddsc_pkg::DATA_BITS-1:0];
        case (regsel)
            ddsc_pkg::REG_DAC:
                rb_val = dv_ff.in_reg[ch];
            ddsc_pkg::REG_CTRL:
                rb_val = {15'h0000, dv_ff.daisy};
            ddsc_pkg::REG_GPIO:
                rb_val = {10'h000, dv_ff.gpi_s2, dv_ff.gp_out,
                          dv_ff.gp_dir};
            default:
                rb_val = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------------
    // Core clock domain
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_dv = dv_ff;
        // Two-stage synchronisers for every pin input
        nxt_dv.frm_s1 = link.frame_n;
        nxt_dv.frm_s2 = dv_ff.frm_s1;
        nxt_dv.frm_d = dv_ff.frm_s2;
        nxt_dv.ld_s1 = link.output_load_n;
        nxt_dv.ld_s2 = dv_ff.ld_s1;
        nxt_dv.ld_d = dv_ff.ld_s2;
        nxt_dv.clr_s1 = link.clear_edge_n;
        nxt_dv.clr_s2 = dv_ff.clr_s1;
        nxt_dv.clr_d = dv_ff.clr_s2;
        nxt_dv.clp_s1 = link.output_clamp_in_n;
        nxt_dv.clp_s2 = dv_ff.clp_s1;
        nxt_dv.mon_s1 = supply_good;
        nxt_dv.mon_s2 = dv_ff.mon_s1;
        nxt_dv.fmt_s1 = code_format_select;
        nxt_dv.fmt_s2 = dv_ff.fmt_s1;
        nxt_dv.gpi_s1 = {gp_pin_one_i, gp_pin_zero_i};
        nxt_dv.gpi_s2 = dv_ff.gpi_s1;
        nxt_dv.mon_out = dv_ff.mon_s2;

        // Load falling edge: move every pending channel together
        if (!dv_ff.ld_s2 && dv_ff.ld_d)
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (dv_ff.pend[i])
                begin
                    nxt_dv.dac_reg[i] = dv_ff.in_reg[i];
                    nxt_dv.pend[i] = 1'b0;
                end
            end
        end

        // Frame rising edge: act on the last word shifted in
        if (dv_ff.frm_s2 && !dv_ff.frm_d)
        begin
            nxt_dv.rb_pend = 1'b0;
            if (rd)
            begin
                nxt_dv.rb_pend = 1'b1;
                nxt_dv.rb_word = {word[ddsc_pkg::WORD_BITS-1:
                                       ddsc_pkg::HDR_LO], rb_val};
            end
            else
            begin
                case (regsel)
                    ddsc_pkg::REG_DAC:
                    begin
                        nxt_dv.in_reg[ch] = data;
                        if (!dv_ff.ld_s2)
                        begin
                            nxt_dv.dac_reg[ch] = data;
                            nxt_dv.pend[ch] = 1'b0;
                        end
                        else
                            nxt_dv.pend[ch] = 1'b1;
                    end
                    ddsc_pkg::REG_CTRL:
                        nxt_dv.daisy = data[ddsc_pkg::CTRL_DAISY_BIT];
                    ddsc_pkg::REG_GPIO:
                    begin
                        nxt_dv.gp_dir = data[ddsc_pkg::GPIO_DIR_LO +: 2];
                        nxt_dv.gp_out = data[ddsc_pkg::GPIO_OUT_LO +: 2];
                    end
                    default:
                        nxt_dv.rb_pend = 1'b0;
                endcase
            end
        end

        // Clear edge comes last so it wins over any update
        if (!dv_ff.clr_s2 && dv_ff.clr_d)
        begin
            nxt_dv.dac_reg[0] = ddsc_pkg::DAC_CLEAR_CODE;
            nxt_dv.dac_reg[1] = ddsc_pkg::DAC_CLEAR_CODE;
        end

        // Output codes; clamping touches only the path, not registers
        for (int i = 0; i < 2; i++)
        begin
            if (!dv_ff.clp_s2)
                nxt_dv.code[i] = ddsc_pkg::ZERO_VOLT_CODE;
            else
                nxt_dv.code[i] = ddsc_pkg::to_offset_binary(
                    nxt_dv.dac_reg[i], dv_ff.fmt_s2);
        end
    end

    // Synchronous reset; idle levels keep edge detectors quiet
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            dv_ff <= '0;
            dv_ff.frm_s1 <= 1'b1;
            dv_ff.frm_s2 <= 1'b1;
            dv_ff.frm_d <= 1'b1;
            dv_ff.ld_s1 <= 1'b1;
            dv_ff.ld_s2 <= 1'b1;
            dv_ff.ld_d <= 1'b1;
            dv_ff.clr_s1 <= 1'b1;
            dv_ff.clr_s2 <= 1'b1;
            dv_ff.clr_d <= 1'b1;
            dv_ff.code <= {ddsc_pkg::ZERO_VOLT_CODE,
                           ddsc_pkg::ZERO_VOLT_CODE};
        end
        else
            dv_ff <= nxt_dv;
    end

    // ------------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------------
    assign gp_pin_zero_o = dv_ff.gp_out[0];
    assign gp_pin_zero_oe = dv_ff.gp_dir[0];
    assign gp_pin_one_o = dv_ff.gp_out[1];
    assign gp_pin_one_oe = dv_ff.gp_dir[1];
    assign link.monitor_reset_out = dv_ff.mon_out;
    assign dac_code_a = dv_ff.code[0];
    assign dac_code_b = dv_ff.code[1];

endmodule // ddsc_dev

// ===== verilog/ddsc_host.sv
// Controller end: APB registers and serial frame generator
`timescale 1ns/1ps
module ddsc_host
#(
    parameter int HALF_CYC = 3,
    parameter int GAP_CYC = ddsc_pkg::FRAME_GAP_CYC
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    ddsc_link_if.host link
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_LEAD, ST_LOW, ST_HIGH, ST_TAIL, ST_GAP
    } ddsc_st_type;

    typedef struct packed {
        ddsc_st_type st;
        logic [7:0] div;
        logic [4:0] bitcnt;
        logic [23:0] tx;
        logic [23:0] rx;
        logic [2:0] ctrl;
        logic sdo_s1;
        logic sdo_s2;
        logic mon_s1;
        logic mon_s2;
        logic sclk;
        logic frame_n;
        logic sdi;
        logic [31:0] rdata;
    } ddsc_host_type;

    ddsc_host_type h_ff;
    ddsc_host_type nxt_h;
    logic wr_acc;
    logic mapped;
    logic busy;
    logic [7:0] half_ld;
    logic [7:0] gap_ld;

    // Reload values sized once; the half period must not drop below
    // the 30 MHz floor, and 3 leaves room for the output synchroniser
    assign half_ld = 8'(HALF_CYC - 1);
    assign gap_ld = 8'(GAP_CYC - 1);
    assign busy = (h_ff.st != ST_IDLE);
    assign mapped = (paddr == ddsc_pkg::OFS_TX)
        || (paddr == ddsc_pkg::OFS_CTRL)
        || (paddr == ddsc_pkg::OFS_STAT)
        || (paddr == ddsc_pkg::OFS_RX);
    // Zero-wait slave; a word write while framing is refused
    assign pready = 1'b1;
    assign pslverr = psel && penable && (!mapped
        || (pwrite && paddr == ddsc_pkg::OFS_TX && busy));
    assign wr_acc = psel && penable && pwrite && !pslverr;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_h = h_ff;
        nxt_h.sdo_s1 = link.serial_bit_out;
        nxt_h.sdo_s2 = h_ff.sdo_s1;
        nxt_h.mon_s1 = link.monitor_reset_out;
        nxt_h.mon_s2 = h_ff.mon_s1;

        // Read data is latched in the setup cycle
        if (psel && !penable)
        begin
            case (paddr)
                ddsc_pkg::OFS_TX: nxt_h.rdata = {8'h00, h_ff.tx};
                ddsc_pkg::OFS_CTRL: nxt_h.rdata = {29'h0, h_ff.ctrl};
                ddsc_pkg::OFS_STAT:
                    nxt_h.rdata = {30'h0, h_ff.mon_s2, busy};
                ddsc_pkg::OFS_RX: nxt_h.rdata = {8'h00, h_ff.rx};
                default: nxt_h.rdata = 32'h0000_0000;
            endcase
        end
        if (wr_acc && paddr == ddsc_pkg::OFS_CTRL)
            nxt_h.ctrl = pwdata[2:0];

        if (h_ff.div != 8'h00)
            nxt_h.div = h_ff.div - 8'h01;
        case (h_ff.st)
            ST_IDLE:
            begin
                if (wr_acc && paddr == ddsc_pkg::OFS_TX)
                begin
                    nxt_h.tx = pwdata[23:0];
                    nxt_h.sdi = pwdata[23];
                    nxt_h.frame_n = 1'b0;
                    nxt_h.bitcnt = 5'h00;
                    nxt_h.div = half_ld;
                    nxt_h.st = ST_LEAD;
                end
            end
            ST_LEAD, ST_HIGH:
            begin
                if (h_ff.div == 8'h00)
                begin
                    // Sample is from the high phase, before the shift
                    nxt_h.rx = {h_ff.rx[22:0], h_ff.sdo_s2};
                    nxt_h.sclk = 1'b0;
                    nxt_h.div = half_ld;
                    nxt_h.st = ST_LOW;
                end
            end
            ST_LOW:
            begin
                if (h_ff.div == 8'h00)
                begin
                    nxt_h.sclk = 1'b1;
                    nxt_h.div = half_ld;
                    if (h_ff.bitcnt == 5'(ddsc_pkg::WORD_BITS - 1))
                        nxt_h.st = ST_TAIL;
                    else
                    begin
                        nxt_h.bitcnt = h_ff.bitcnt + 5'h01;
                        nxt_h.tx = {h_ff.tx[22:0], 1'b0};
                        nxt_h.sdi = h_ff.tx[22];
                        nxt_h.st = ST_HIGH;
                    end
                end
            end
            ST_TAIL:
            begin
                if (h_ff.div == 8'h00)
                begin
                    nxt_h.frame_n = 1'b1;
                    nxt_h.div = gap_ld;
                    nxt_h.st = ST_GAP;
                end
            end
            ST_GAP:
            begin
                if (h_ff.div == 8'h00)
                    nxt_h.st = ST_IDLE;
            end
            default:
                nxt_h.st = ST_IDLE;
        endcase
    end

    // Synchronous reset; clock idles high, frame inactive
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            h_ff <= '0;
            h_ff.st <= ST_IDLE;
            h_ff.ctrl <= ddsc_pkg::CTRL_RESET;
            h_ff.sclk <= 1'b1;
            h_ff.frame_n <= 1'b1;
        end
        else
            h_ff <= nxt_h;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata = h_ff.rdata;
    assign link.sclk = h_ff.sclk;
    assign link.frame_n = h_ff.frame_n;
    assign link.serial_bit_in = h_ff.sdi;
    assign link.output_load_n = h_ff.ctrl[ddsc_pkg::CTRL_LOAD_BIT];
    assign link.clear_edge_n = h_ff.ctrl[ddsc_pkg::CTRL_CLEAR_BIT];
    assign link.output_clamp_in_n = h_ff.ctrl[ddsc_pkg::CTRL_CLAMP_BIT];

endmodule // ddsc_host

// ===== test/ddsc_link_asserts.sv
// Checker for the serial link between controller and converter
`timescale 1ns/1ps
module ddsc_link_asserts
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic frame_n,
    input wire logic serial_bit_in,
    input wire logic serial_bit_out,
    input wire logic output_load_n,
    input wire logic clear_edge_n,
    input wire logic output_clamp_in_n,
    input wire logic monitor_reset_out
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // Falls seen in the open frame; cleared between frames
    logic [5:0] falls_ff;
    always_ff @(posedge core_clk)
    begin
        if (!reset_n || frame_n)
            falls_ff <= 6'h00;
        else if ($fell(sclk))
            falls_ff <= falls_ff + 6'h01;
    end

    // Frame opens with three high cycles before the first fall
    sequence s_frame_open;
        sclk [*3] ##1 !sclk;
    endsequence

    AST_SCLK_IDLE: assert property (frame_n |-> sclk)
        else $error("serial clock low outside a frame");
    AST_FRAME_OPEN: assert property ($fell(frame_n) |-> s_frame_open)
        else $error("first serial clock fall misplaced");
    AST_HALF_PERIOD: assert property (!frame_n && $changed(sclk)
        |=> $stable(sclk) [*2])
        else $error("serial clock phase shorter than three cycles");
    AST_DATA_HOLD: assert property (!frame_n && $changed(serial_bit_in)
        |-> $rose(sclk) || $fell(frame_n))
        else $error("serial data moved away from the rising clock");
    AST_WORD_BITS: assert property ($rose(frame_n) |-> falls_ff == 6'h18)
        else $error("frame did not carry 24 clock falls");
    AST_LAST_RISE: assert property ($rose(frame_n)
        |-> $past(sclk, 3) && !$past(sclk, 4))
        else $error("frame closed at the wrong distance from last rise");
    AST_FRAME_GAP: assert property ($rose(frame_n) |-> frame_n [*8])
        else $error("frame reopened too soon");
    AST_RESET_LEVELS: assert property ($rose(reset_n) |-> frame_n && sclk
        && output_load_n && clear_edge_n && output_clamp_in_n)
        else $error("control lines not at idle levels after reset");
endmodule // ddsc_link_asserts

// ===== test/dual_dac_serial_control_bench.sv
// Testbench joining controller and converter ends over the link
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin num_errors++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module dual_dac_serial_control_bench;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fmt_sel = 1'b0;
    logic supply_good = 1'b1;
    logic gp0_o, gp0_oe, gp1_o, gp1_oe;
    logic [15:0] dac_a, dac_b, v, w1, w2, y, z;
    logic [31:0] dac_q[$];
    logic [31:0] rd_q[$];
    logic [31:0] last_pair, exp_v;
    logic mon_on = 1'b0;
    logic err, err2;
    int num_errors = 0;
    int samples_checked = 0;

    // ------------------------------------------------------------------
    // Clock, ends and checker
    // ------------------------------------------------------------------
    always #5 core_clk = ~core_clk;
    ddsc_link_if link();
    ddsc_host u_ddsc_host (.core_clk(core_clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link.host));
    // Undriven general pins: zero pulled up, one held low by the board
    ddsc_dev u_ddsc_dev (.core_clk(core_clk), .reset_n(reset_n),
        .link(link.dev), .code_format_select(fmt_sel),
        .supply_good(supply_good), .gp_pin_zero_i(gp0_oe ? gp0_o : 1'b1),
        .gp_pin_zero_o(gp0_o), .gp_pin_zero_oe(gp0_oe),
        .gp_pin_one_i(gp1_oe ? gp1_o : 1'b0), .gp_pin_one_o(gp1_o),
        .gp_pin_one_oe(gp1_oe), .dac_code_a(dac_a), .dac_code_b(dac_b));
    ddsc_link_asserts u_ddsc_link_asserts (.core_clk(core_clk),
        .reset_n(reset_n), .sclk(link.sclk), .frame_n(link.frame_n),
        .serial_bit_in(link.serial_bit_in),
        .serial_bit_out(link.serial_bit_out),
        .output_load_n(link.output_load_n),
        .clear_edge_n(link.clear_edge_n),
        .output_clamp_in_n(link.output_clamp_in_n),
        .monitor_reset_out(link.monitor_reset_out));

    // Result watcher: noted reads and every change of the code pair
    always @(posedge core_clk)
    begin
        if (psel && penable && pready && !pwrite &&
            paddr != ddsc_pkg::OFS_STAT && rd_q.size() > 0)
        begin
            exp_v = rd_q.pop_front();
            `CHK("rx word", exp_v, prdata)
        end
        if (mon_on && {dac_a, dac_b} !== last_pair)
        begin
            exp_v = (dac_q.size() > 0) ? dac_q.pop_front() : 32'hXXXXXXXX;
            `CHK("dac pair", exp_v, {dac_a, dac_b})
            last_pair = {dac_a, dac_b};
        end
    end

    task automatic finish_test();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One APB transfer; an extra edge keeps strobes from double assignment
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            num_errors++;
            finish_test();
        end
        @(posedge core_clk);
    endtask

    // Poll busy with a bound; a hung frame ends the run
    task automatic idle();
        int n;
        for (n = 0; n < 100; n++)
        begin
            apb(1'b0, ddsc_pkg::OFS_STAT, 32'h0);
            if (prdata[ddsc_pkg::STAT_BUSY_BIT] === 1'b0)
                break;
        end
        if (n >= 100)
        begin
            num_errors++;
            finish_test();
        end
    endtask

    task automatic send(input logic [23:0] w);
        apb(1'b1, ddsc_pkg::OFS_TX, {8'h00, w});
        idle();
    endtask

    function automatic logic [23:0] wd(input logic rd,
        input logic [2:0] rg, input logic ch, input logic [15:0] d);
        return {rd, 1'b0, rg, 2'b00, ch, d};
    endfunction

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(79));
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        last_pair = {dac_a, dac_b};
        mon_on = 1'b1;
        `CHK("reset codes", 32'h80008000, last_pair)
        v = 16'($urandom()) | 16'h0001;
        apb(1'b1, ddsc_pkg::OFS_CTRL, 32'h6);
        dac_q.push_back({v ^ 16'h8000, 16'h8000});
        send(wd(1'b0, ddsc_pkg::REG_DAC, 1'b0, v));
        $display("test immediate done");
        // Held load: nothing moves until it falls, then both move
        w1 = 16'($urandom()) | 16'h0001;
        w2 = 16'($urandom()) | 16'h0001;
        apb(1'b1, ddsc_pkg::OFS_CTRL, 32'h7);
        send(wd(1'b0, ddsc_pkg::REG_DAC, 1'b0, w1));
        send(wd(1'b0, ddsc_pkg::REG_DAC, 1'b1, w2));
        dac_q.push_back({w1 ^ 16'h8000, w2 ^ 16'h8000});
        apb(1'b1, ddsc_pkg::OFS_CTRL, 32'h6);
        dac_q.push_back(32'h80008000);
        apb(1'b1, ddsc_pkg::OFS_CTRL, 32'h4);
        apb(1'b1, ddsc_pkg::OFS_CTRL, 32'h6);
        $display("test load and clear done");
        // Clamp keeps registers; strap flipped while clamped
        y = 16'($urandom()) | 16'h0001;
        dac_q.push_back({y ^ 16'h8000, 16'h8000});
        send(wd(1'b0, ddsc_pkg::REG_DAC, 1'b0, y));
        dac_q.push_back(32'h80008000);
        apb(1'b1, ddsc_pkg::OFS_CTRL, 32'h2);
        repeat (6) @(posedge core_clk);
        fmt_sel <= 1'b1;
        z = 16'($urandom()) | 16'h0001;
        send(wd(1'b0, ddsc_pkg::REG_DAC, 1'b1, z));
        dac_q.push_back({y, z});
        apb(1'b1, ddsc_pkg::OFS_CTRL, 32'h6);
        $display("test clamp done");
        // General pins and readback in the following frame
        send(wd(1'b0, ddsc_pkg::REG_GPIO, 1'b0, 16'h0005));
        `CHK("gp0 oe", 1'b1, gp0_oe)
        `CHK("gp0 level", 1'b1, gp0_o)
        `CHK("gp1 oe", 1'b0, gp1_oe)
        send(wd(1'b1, ddsc_pkg::REG_GPIO, 1'b0, 16'h0000));
        send(wd(1'b0, ddsc_pkg::REG_CTRL, 1'b0, 16'h0000));
        rd_q.push_back(32'h00900015);
        apb(1'b0, ddsc_pkg::OFS_RX, 32'h0);
        send(wd(1'b1, ddsc_pkg::REG_DAC, 1'b1, 16'h0000));
        send(wd(1'b0, ddsc_pkg::REG_CTRL, 1'b0, 16'h0000));
        rd_q.push_back({16'h0081, z});
        apb(1'b0, ddsc_pkg::OFS_RX, 32'h0);
        $display("test readback done");
        // Daisy chain; a second word during a frame is refused
        send(wd(1'b0, ddsc_pkg::REG_CTRL, 1'b0, 16'h0001));
        apb(1'b1, ddsc_pkg::OFS_TX, 32'h00080000);
        apb(1'b1, ddsc_pkg::OFS_TX, 32'h00FFFFFF);
        err2 = err;
        apb(1'b0, 8'h10, 32'h0);
        `CHK("refusals", 2'h3, {err2, err})
        idle();
        rd_q.push_back(32'h00080001);
        apb(1'b0, ddsc_pkg::OFS_RX, 32'h0);
        $display("test daisy done");
        supply_good <= 1'b0;
        repeat (5) @(posedge core_clk);
        `CHK("monitor low", 1'b0, link.monitor_reset_out)
        apb(1'b0, ddsc_pkg::OFS_STAT, 32'h0);
        `CHK("stat monitor", 1'b0, prdata[ddsc_pkg::STAT_MON_BIT])
        supply_good <= 1'b1;
        repeat (5) @(posedge core_clk);
        `CHK("monitor high", 1'b1, link.monitor_reset_out)
        repeat (10) @(posedge core_clk);
        `CHK("notes left", 32'h0, 32'(dac_q.size()))
        $display("test monitor done");
        finish_test();
    end
endmodule // dual_dac_serial_control_bench
